/* File: logic/drc_pkg.sv */
// package: register map, field layout and decoded config types for the receiver config bank
package drc_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] CHAN_CFG_OFFSET = 8'h10;
  localparam logic [7:0] EQUALIZE_OFFSET = 8'h11;
  localparam logic [7:0] CHAN_CFG_RESET  = 8'h3E;
  localparam logic [7:0] EQUALIZE_RESET  = 8'h00;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int PIXEL_SPLIT_BIT   = 7;
  localparam int CHAN_MODE_LSB     = 5;
  localparam int CHAN_A_LANES_LSB  = 3;
  localparam int CHAN_B_LANES_LSB  = 1;
  localparam int STRICT_LEADER_BIT = 0;
  localparam int CHAN_A_DATA_LSB   = 6;
  localparam int CHAN_B_DATA_LSB   = 4;
  localparam int CHAN_A_CLOCK_LSB  = 2;
  localparam int CHAN_B_CLOCK_LSB  = 0;

  // ------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------
  localparam logic [1:0] MODE_DUAL     = 2'h0;
  localparam logic [1:0] MODE_SINGLE   = 2'h1;
  localparam logic [1:0] MODE_TWO_SING = 2'h2;
  localparam logic [1:0] EQ_NONE       = 2'h0;
  localparam logic [1:0] EQ_1DB        = 2'h1;
  localparam logic [1:0] EQ_RESERVED   = 2'h2;
  localparam logic [1:0] EQ_2DB        = 2'h3;
  localparam logic [1:0] AXI_OKAY      = 2'h0;
  localparam logic [1:0] AXI_SLVERR    = 2'h2;

  // ------------------------------------------------------------
  // decoded controls
  // ------------------------------------------------------------
  typedef struct packed {
    logic       left_right_split;
    logic [1:0] chan_mode;
    logic [2:0] chan_a_lane_count;
    logic [2:0] chan_b_lane_count;
    logic       strict_leader_check;
    logic       dual_link_out;
    logic       two_single_link_out;
  } drc_chan_cfg_t;

  typedef struct packed {
    logic [1:0] chan_a_data_equalize;
    logic [1:0] chan_b_data_equalize;
    logic [1:0] chan_a_clock_equalize;
    logic [1:0] chan_b_clock_equalize;
  } drc_equalize_t;

  // lanes code 00..11 means four..one lanes
  function automatic logic [2:0] lanes_of(input logic [1:0] code);
    lanes_of = 3'h4 - {1'b0, code};
  endfunction : lanes_of

endpackage : drc_pkg

/* File: logic/drc_regs.sv */
// receiver channel config and equalization registers behind an AXI4-Lite slave
//
// Function
// [R1] bit 7 of channel config: 0 odd/even split, 1 left/right halves
// [R2] bits 6-5 channel mode: 00 dual, 01 single (reset), 10 two single
// [R3] bits 4-3 channel A lanes: 00 four down to 11 one (reset)
// [R4] bits 2-1 channel B lanes, same coding, reset one lane
// [R5] bit 0 zero tolerates one leader bit error; one tolerates none
// [R6] equalize bits 7-6 channel A data: 00 none, 01 1dB, 11 2dB
// [R7] equalize bits 5-4 channel B data, same coding, reset none
// [R8] bits 3-2 and 1-0 clock lane equalize for A and B
// [R9] with outputs enabled, modes 00/01 dual link, 10 two single links
// [R10] all fields read-write, read back last write, reset to listed values
//
// Local design decision: the AXI4-Lite slave port.
module drc_regs (
  // clock and reset
  input  wire  logic                  aclk,
  input  wire  logic                  aresetn,
  // axi4-lite write
  input  wire  logic [7:0]            s_axi_awaddr,
  input  wire  logic                  s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire  logic [31:0]           s_axi_wdata,
  input  wire  logic [3:0]            s_axi_wstrb,
  input  wire  logic                  s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire  logic                  s_axi_bready,
  // axi4-lite read
  input  wire  logic [7:0]            s_axi_araddr,
  input  wire  logic                  s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire  logic                  s_axi_rready,
  // decoded controls
  output drc_pkg::drc_chan_cfg_t      chan_cfg,
  output drc_pkg::drc_equalize_t      equalize
);

  // ------------------------------------------------------------
  // storage and bus state
  // ------------------------------------------------------------
  logic [7:0]  chan_cfg_ff;
  logic [7:0]  equalize_ff;
  logic        aw_held_ff;
  logic [7:0]  awaddr_ff;
  logic        w_held_ff;
  logic [31:0] wdata_ff;
  logic        wstrb0_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [1:0]  rresp_ff;
  logic [31:0] rdata_ff;

  // registers sit one word apart: byte address is four times the index
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] index);
    addr_is = addr == {index[5:0], 2'h0};
  endfunction : addr_is

  // ------------------------------------------------------------
  // write path
  // ------------------------------------------------------------
  wire        aw_take  = s_axi_awvalid && s_axi_awready;
  wire        w_take   = s_axi_wvalid && s_axi_wready;
  wire        aw_have  = aw_held_ff || s_axi_awvalid;
  wire        w_have   = w_held_ff || s_axi_wvalid;
  wire        do_write = aw_have && w_have && !bvalid_ff;
  wire [7:0]  wr_addr  = aw_held_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0] wr_data  = w_held_ff ? wdata_ff : s_axi_wdata;
  wire        wr_lane0 = w_held_ff ? wstrb0_ff : s_axi_wstrb[0];
  wire        wr_cfg   = do_write && addr_is(wr_addr, drc_pkg::CHAN_CFG_OFFSET);
  wire        wr_eq    = do_write && addr_is(wr_addr, drc_pkg::EQUALIZE_OFFSET);
  wire        wr_hit   = wr_cfg || wr_eq;

  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb0_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= drc_pkg::AXI_OKAY;
    end else begin
      if (aw_take && !do_write) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_ff <= 1'b0;
      end
      if (w_take && !do_write) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb0_ff <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_held_ff <= 1'b0;
      end
      if (do_write) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_hit ? drc_pkg::AXI_OKAY : drc_pkg::AXI_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // register storage; lane 0 carries the byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_cfg_ff <= drc_pkg::CHAN_CFG_RESET; // R1 R2 R3 R4 R5 R10
      equalize_ff <= drc_pkg::EQUALIZE_RESET; // R6 R7 R8 R10
    end else begin
      if (wr_cfg && wr_lane0) begin
        chan_cfg_ff <= wr_data[7:0]; // R10
      end
      if (wr_eq && wr_lane0) begin
        equalize_ff <= wr_data[7:0]; // R10
      end
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  wire       ar_take = s_axi_arvalid && s_axi_arready;
  wire       rd_cfg  = addr_is(s_axi_araddr, drc_pkg::CHAN_CFG_OFFSET);
  wire       rd_eq   = addr_is(s_axi_araddr, drc_pkg::EQUALIZE_OFFSET);
  wire [7:0] rd_byte = rd_cfg ? chan_cfg_ff : (rd_eq ? equalize_ff : 8'h00);

  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= drc_pkg::AXI_OKAY;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {24'h00_0000, rd_byte}; // R10
      rresp_ff  <= (rd_cfg || rd_eq) ? drc_pkg::AXI_OKAY : drc_pkg::AXI_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // decoded controls
  // ------------------------------------------------------------
  wire [1:0] mode_f = chan_cfg_ff[drc_pkg::CHAN_MODE_LSB +: 2];

  assign chan_cfg.left_right_split    = chan_cfg_ff[drc_pkg::PIXEL_SPLIT_BIT]; // R1
  assign chan_cfg.chan_mode           = mode_f; // R2
  assign chan_cfg.chan_a_lane_count   =
    drc_pkg::lanes_of(chan_cfg_ff[drc_pkg::CHAN_A_LANES_LSB +: 2]); // R3
  assign chan_cfg.chan_b_lane_count   =
    drc_pkg::lanes_of(chan_cfg_ff[drc_pkg::CHAN_B_LANES_LSB +: 2]); // R4
  assign chan_cfg.strict_leader_check = chan_cfg_ff[drc_pkg::STRICT_LEADER_BIT]; // R5
  assign chan_cfg.dual_link_out       =
    mode_f == drc_pkg::MODE_DUAL || mode_f == drc_pkg::MODE_SINGLE; // R9
  assign chan_cfg.two_single_link_out = mode_f == drc_pkg::MODE_TWO_SING; // R9

  assign equalize.chan_a_data_equalize  = equalize_ff[drc_pkg::CHAN_A_DATA_LSB +: 2]; // R6
  assign equalize.chan_b_data_equalize  = equalize_ff[drc_pkg::CHAN_B_DATA_LSB +: 2]; // R7
  assign equalize.chan_a_clock_equalize = equalize_ff[drc_pkg::CHAN_A_CLOCK_LSB +: 2]; // R8
  assign equalize.chan_b_clock_equalize = equalize_ff[drc_pkg::CHAN_B_CLOCK_LSB +: 2]; // R8

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  cfg_write_a : assert property (@(posedge aclk) disable iff (!aresetn) // R10
    wr_cfg && wr_lane0 |=> chan_cfg_ff == $past(wr_data[7:0]))
    else $error("config write not stored");
  eq_write_a : assert property (@(posedge aclk) disable iff (!aresetn) // R10
    wr_eq && wr_lane0 |=> equalize_ff == $past(wr_data[7:0]))
    else $error("equalize write not stored");
  cfg_hold_a : assert property (@(posedge aclk) disable iff (!aresetn) // R10
    !wr_cfg |=> $stable(chan_cfg_ff))
    else $error("config changed without write");
  reset_val_a : assert property (@(posedge aclk) // R2
    !aresetn |=> chan_cfg_ff == 8'h3E && equalize_ff == 8'h00)
    else $error("reset values wrong");
  lane_a_a : assert property (@(posedge aclk) disable iff (!aresetn) // R3
    chan_cfg_ff[4:3] == 2'h3 |-> chan_cfg.chan_a_lane_count == 3'h1)
    else $error("channel A lane decode wrong");
  lane_b_a : assert property (@(posedge aclk) disable iff (!aresetn) // R4
    chan_cfg_ff[2:1] == 2'h0 |-> chan_cfg.chan_b_lane_count == 3'h4)
    else $error("channel B lane decode wrong");
  link_mode_a : assert property (@(posedge aclk) disable iff (!aresetn) // R9
    chan_cfg_ff[6:5] == 2'h2 |-> chan_cfg.two_single_link_out && !chan_cfg.dual_link_out)
    else $error("link arrangement wrong");
  read_back_a : assert property (@(posedge aclk) disable iff (!aresetn) // R10
    ar_take && rd_eq |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(equalize_ff))
    else $error("read data wrong");
  write_resp_a : assert property (@(posedge aclk) disable iff (!aresetn) // R10
    do_write |=> s_axi_bvalid [*1] ##0 (s_axi_bresp == drc_pkg::AXI_OKAY) == $past(wr_hit))
    else $error("write response wrong");
  eq_hold_a : assert property (@(posedge aclk) disable iff (!aresetn) // R10
    !wr_eq |=> $stable(equalize_ff))
    else $error("equalize changed without write");
  lane_off_a : assert property (@(posedge aclk) disable iff (!aresetn) // R10
    wr_cfg && !wr_lane0 |=> $stable(chan_cfg_ff))
    else $error("config stored with lane 0 off");
  unmapped_read_a : assert property (@(posedge aclk) disable iff (!aresetn) // R10
    ar_take && !rd_cfg && !rd_eq |=>
      s_axi_rresp == drc_pkg::AXI_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read answered wrongly");
  dual_link_a : assert property (@(posedge aclk) disable iff (!aresetn) // R9
    chan_cfg_ff[6:5] inside {2'h0, 2'h1} |->
      chan_cfg.dual_link_out && !chan_cfg.two_single_link_out)
    else $error("dual link arrangement wrong");
  lane_three_a : assert property (@(posedge aclk) disable iff (!aresetn) // R3
    chan_cfg_ff[4:3] == 2'h1 |-> chan_cfg.chan_a_lane_count == 3'h3)
    else $error("channel A three lane decode wrong");
  reset_idle_a : assert property (@(posedge aclk) // R10
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && s_axi_arready)
    else $error("bus not idle after reset");

endmodule : drc_regs

/* File: tb/dsi_rx_config_regs_tb_top.sv */
// testbench for the receiver channel config and equalization register bank
module dsi_rx_config_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic                   aclk          = 1'b0;
  logic                   aresetn       = 1'b0;
  logic [7:0]             s_axi_awaddr  = 8'h00;
  logic                   s_axi_awvalid = 1'b0;
  logic                   s_axi_awready;
  logic [31:0]            s_axi_wdata   = 32'h0;
  logic [3:0]             s_axi_wstrb   = 4'h0;
  logic                   s_axi_wvalid  = 1'b0;
  logic                   s_axi_wready;
  logic [1:0]             s_axi_bresp;
  logic                   s_axi_bvalid;
  logic                   s_axi_bready  = 1'b0;
  logic [7:0]             s_axi_araddr  = 8'h00;
  logic                   s_axi_arvalid = 1'b0;
  logic                   s_axi_arready;
  logic [31:0]            s_axi_rdata;
  logic [1:0]             s_axi_rresp;
  logic                   s_axi_rvalid;
  logic                   s_axi_rready  = 1'b0;
  drc_pkg::drc_chan_cfg_t chan_cfg;
  drc_pkg::drc_equalize_t equalize;
  int                     err_count     = 0;
  int                     tests_run     = 0;
  logic [7:0]             cfg_sh        = 8'h3E;
  logic [7:0]             eq_sh         = 8'h00;
  wire  [4:0]             bus_idle      = {s_axi_awready, s_axi_wready, s_axi_bvalid,
                                           s_axi_arready, s_axi_rvalid};

  // registers sit one word apart: byte address is four times the index
  localparam logic [7:0]  CFG_ADDR = {drc_pkg::CHAN_CFG_OFFSET[5:0], 2'h0};
  localparam logic [7:0]  EQ_ADDR  = {drc_pkg::EQUALIZE_OFFSET[5:0], 2'h0};

  // lane code to lane count
  localparam logic [2:0]  LANES [4] = '{3'h4, 3'h3, 3'h2, 3'h1};
  // rows: byte address, data
  localparam logic [15:0] ROWS [10] = '{16'h4080, 16'h4027, 16'h404B, 16'h40F4,
    16'h445F, 16'h44E4, 16'h441B, 16'h10FF, 16'h42AA, 16'h003C};

  drc_regs dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .chan_cfg(chan_cfg), .equalize(equalize)
  );

  initial begin
    forever #20 aclk = ~aclk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic end_of_test();
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                        output logic [1:0] resp);
    int   n;
    logic aw_t, w_t, seen;
    n = 0;
    seen = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {24'hC3C3C3, d};
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!seen && n < 50) begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t  = s_axi_wvalid && s_axi_wready;
      seen = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      n++;
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!seen) begin
      err_count++;
      end_of_test();
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int   n;
    logic ar_t, seen;
    n = 0;
    seen = 1'b0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!seen && n < 50) begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      seen = s_axi_rvalid;
      d    = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      n++;
      if (ar_t) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    // one idle edge so a following read does not raise rready in the same step
    @(posedge aclk);
    if (!seen) begin
      err_count++;
      end_of_test();
    end
  endtask : axi_rd

  function automatic drc_pkg::drc_chan_cfg_t exp_cfg(input logic [7:0] v);
    exp_cfg = '{v[7], v[6:5], LANES[v[4:3]], LANES[v[2:1]], v[0],
                (v[6:5] == 2'h0) || (v[6:5] == 2'h1), v[6:5] == 2'h2};
  endfunction : exp_cfg

  task automatic check_all();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(CFG_ADDR, d, r);
    chk(d, {24'h0, cfg_sh});
    chk({30'h0, r}, {30'h0, drc_pkg::AXI_OKAY});
    chk({20'h0, chan_cfg}, {20'h0, exp_cfg(cfg_sh)});
    axi_rd(EQ_ADDR, d, r);
    chk(d, {24'h0, eq_sh});
    chk({24'h0, equalize}, {24'h0, eq_sh});
  endtask : check_all

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0]  a;
    logic [7:0]  d;
    logic [31:0] rd;
    logic [1:0]  r;
    logic        mapped;
    repeat (15) @(posedge aclk);
    @(negedge aclk);
    chk({27'h0, bus_idle}, 32'h0000_001A);
    @(posedge aclk);
    aresetn <= 1'b1;
    check_all();
    foreach (ROWS[i]) begin
      a = ROWS[i][15:8];
      d = ROWS[i][7:0];
      mapped = (a == CFG_ADDR) || (a == EQ_ADDR);
      axi_wr(a, d, 4'hF, r);
      chk({30'h0, r}, {30'h0, mapped ? drc_pkg::AXI_OKAY : drc_pkg::AXI_SLVERR});
      if (a == CFG_ADDR) cfg_sh = d;
      if (a == EQ_ADDR) eq_sh = d;
      if (!mapped) begin
        axi_rd(a, rd, r);
        chk(rd, 32'h0);
        chk({30'h0, r}, {30'h0, drc_pkg::AXI_SLVERR});
      end
      check_all();
    end
    // disabled byte lane leaves the register untouched
    axi_wr(CFG_ADDR, 8'h00, 4'h0, r);
    chk({30'h0, r}, {30'h0, drc_pkg::AXI_OKAY});
    check_all();
    // reset in mid-run restores the listed values
    aresetn <= 1'b0;
    @(posedge aclk);
    @(negedge aclk);
    chk({27'h0, bus_idle}, 32'h0000_001A);
    @(posedge aclk);
    aresetn <= 1'b1;
    cfg_sh = 8'h3E;
    eq_sh  = 8'h00;
    check_all();
    end_of_test();
  end

endmodule : dsi_rx_config_regs_tb_top
